// ---- design/ssw_pkg.sv ----
// constants and types shared by the supply supervisor watchdog design
package ssw_pkg;

  // ==========================================================================
  // clock and timing
  // ==========================================================================
  localparam int unsigned CLK_MHZ          = 100;
  localparam int unsigned EXT_FILTER_NS    = 1000;  // external threshold filter, least
  localparam int unsigned DEEP_FILTER_NS   = 1000;  // internal filter, dip to 2.5 V, least
  localparam int unsigned SHALLOW_FILTER_NS = 4000; // internal filter, shallow dip
  // least times round up to whole cycles
  localparam int unsigned EXT_FILTER_CYC     = (EXT_FILTER_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned DEEP_FILTER_CYC    = (DEEP_FILTER_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned SHALLOW_FILTER_CYC = (SHALLOW_FILTER_NS * CLK_MHZ + 999) / 1000;

  // ==========================================================================
  // oscillator period counts
  // ==========================================================================
  localparam int unsigned RECOVERY_PERIODS = 127;
  localparam int unsigned WD_WINDOW_PERIODS = 48;
  localparam int unsigned WD_HOLD_PERIODS  = 16;

  // ==========================================================================
  // counter widths
  // ==========================================================================
  localparam int unsigned UV_CNT_W   = 10;
  localparam int unsigned REC_CNT_W  = 7;
  localparam int unsigned WD_CNT_W   = 6;
  localparam int unsigned HOLD_CNT_W = 5;
  localparam int unsigned RF_CNT_W   = 16;

  // ==========================================================================
  // pin synchroniser lanes
  // ==========================================================================
  localparam int unsigned PIN_COUNT     = 4;
  localparam int unsigned PIN_KICK      = 0;
  localparam int unsigned PIN_WD_ENABLE = 1;
  localparam int unsigned PIN_THR_ADJ   = 2;
  localparam int unsigned PIN_AUX_EN    = 3;

  // ==========================================================================
  // register map (byte offsets)
  // ==========================================================================
  localparam logic [3:0]  CTRL_OFS      = 4'h0;
  localparam logic [3:0]  RSTFILT_OFS   = 4'h4;
  localparam logic [3:0]  STATUS_OFS    = 4'h8;
  localparam int unsigned CTRL_AUXMON_BIT = 0;
  localparam logic [RF_CNT_W-1:0] RSTFILT_RESET = 16'h0064;
  localparam int unsigned ST_FAULT_N_BIT  = 0;
  localparam int unsigned ST_RESET_N_BIT  = 1;
  localparam int unsigned ST_UV_LSB       = 2;
  localparam int unsigned ST_WD_LSB       = 4;
  localparam int unsigned ST_CHARGING_BIT = 6;
  localparam int unsigned ST_RAMP_BIT     = 7;
  localparam int unsigned ST_WDCNT_LSB    = 8;

  // ==========================================================================
  // state encodings (gray along the usual path)
  // ==========================================================================
  typedef enum logic [1:0] {
    SSW_UV_OK    = 2'b00,
    SSW_UV_FILT  = 2'b01,
    SSW_UV_LOW   = 2'b11,
    SSW_UV_RECOV = 2'b10
  } ssw_uv_e;

  typedef enum logic [1:0] {
    SSW_WD_OFF  = 2'b00,
    SSW_WD_RUN  = 2'b01,
    SSW_WD_HOLD = 2'b11
  } ssw_wd_e;

endpackage

// ---- design/ssw_pin_sync.sv ----
// three-stage synchroniser with agreement filter for asynchronous pins
`timescale 1ns/1ns
module ssw_pin_sync (
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst,
  // pins and cleaned levels
  input  wire logic [ssw_pkg::PIN_COUNT-1:0] pin_async,
  output wire logic [ssw_pkg::PIN_COUNT-1:0] pin_clean
);

  typedef struct packed {
    logic [ssw_pkg::PIN_COUNT-1:0] s1;
    logic [ssw_pkg::PIN_COUNT-1:0] s2;
    logic [ssw_pkg::PIN_COUNT-1:0] s3;
    logic [ssw_pkg::PIN_COUNT-1:0] clean;
  } ssw_sync_s;

  ssw_sync_s st_q;
  ssw_sync_s st_d;
  logic [ssw_pkg::PIN_COUNT-1:0] clean_next;

  // a lane changes only when stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < ssw_pkg::PIN_COUNT; gi = gi + 1) begin : g_lane
      assign clean_next[gi] = (st_q.s2[gi] == st_q.s3[gi]) ? st_q.s3[gi] : st_q.clean[gi];
    end
  endgenerate

  // shift chain
  always_comb begin
    st_d       = st_q;
    st_d.s1    = pin_async;
    st_d.s2    = st_q.s1;
    st_d.s3    = st_q.s2;
    st_d.clean = clean_next;
  end

  // state register
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign pin_clean = st_q.clean;

endmodule

// ---- design/ssw_supervisor.sv ----
// supply supervisor with undervoltage reset, capacitor oscillator and watchdog
//
// The Avalon-MM register port and the register offsets were decided locally.
`timescale 1ns/1ns
module ssw_supervisor (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // synchronous comparator and oscillator inputs
  input  wire logic        vcc_below_threshold,
  input  wire logic        vcc_below_2v5,
  input  wire logic        vcc_below_2v0,
  input  wire logic        aux_undervoltage,
  input  wire logic        osc_tick,
  // asynchronous pins
  input  wire logic        watchdog_kick,
  input  wire logic        watchdog_enable_pin,
  input  wire logic        threshold_adjust,
  input  wire logic        aux_enable,
  // pin outputs
  output wire logic        fault_n,
  output wire logic        reset_n,
  output wire logic        aux_output_on,
  output wire logic        delay_capacitor_charge,
  output wire logic        delay_capacitor_clamp,
  // avalon-mm slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output wire logic [31:0] avs_readdata,
  output wire logic        avs_waitrequest
);

  // ==========================================================================
  // state
  // ==========================================================================
  typedef struct packed {
    ssw_pkg::ssw_uv_e                  uv;
    logic [ssw_pkg::UV_CNT_W-1:0]      uv_cnt;
    logic [ssw_pkg::REC_CNT_W-1:0]     rec_cnt;
    ssw_pkg::ssw_wd_e                  wd;
    logic [ssw_pkg::WD_CNT_W-1:0]      wd_cnt;
    logic [ssw_pkg::HOLD_CNT_W-1:0]    hold_cnt;
    logic                              charging;
    logic                              ramp_done;
    logic                              kick_prev;
    logic [ssw_pkg::RF_CNT_W-1:0]      rf_cnt;
    logic                              aux_mon;
    logic [ssw_pkg::RF_CNT_W-1:0]      rf_limit;
    logic                              fault_n;
    logic                              reset_n;
    logic                              aux_on;
    logic                              cap_charge;
    logic                              cap_clamp;
    logic                              waitreq;
    logic [31:0]                       rdata;
  } ssw_state_s;

  ssw_state_s st_q;
  ssw_state_s st_d;

  // ==========================================================================
  // pin synchronisation
  // ==========================================================================
  logic [ssw_pkg::PIN_COUNT-1:0] pins_raw;
  logic [ssw_pkg::PIN_COUNT-1:0] pins;

  assign pins_raw = {aux_enable, threshold_adjust, watchdog_enable_pin, watchdog_kick};

  ssw_pin_sync u_sync (
    .clk       (clk),
    .rst       (rst),
    .pin_async (pins_raw),
    .pin_clean (pins)
  );

  // ==========================================================================
  // helpers
  // ==========================================================================
  // word select shared by read and write decode
  function automatic logic [1:0] reg_word(input logic [3:0] addr);
    reg_word = addr[3:2];
  endfunction

  // byte-lane merge for writes
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    lane_merge = r;
  endfunction

  logic                          kick_rise;
  logic                          wd_enabled;
  logic                          ext_thr;
  logic                          cap_active;
  logic                          period_end;
  logic [ssw_pkg::UV_CNT_W-1:0]  uv_target;
  logic                          wd_kick_taken;
  logic                          fault_now;
  logic [31:0]                   status_word;
  logic [31:0]                   merged;

  // ==========================================================================
  // next-state logic
  // ==========================================================================
  always_comb begin
    st_d       = st_q;
    kick_rise  = pins[ssw_pkg::PIN_KICK] & ~st_q.kick_prev;
    wd_enabled = pins[ssw_pkg::PIN_WD_ENABLE];
    ext_thr    = pins[ssw_pkg::PIN_THR_ADJ];
    st_d.kick_prev = pins[ssw_pkg::PIN_KICK];

    // filter length by threshold source and dip depth
    if (ext_thr) begin
      uv_target = ssw_pkg::UV_CNT_W'(ssw_pkg::EXT_FILTER_CYC);
    end else if (vcc_below_2v5) begin
      uv_target = ssw_pkg::UV_CNT_W'(ssw_pkg::DEEP_FILTER_CYC);
    end else begin
      uv_target = ssw_pkg::UV_CNT_W'(ssw_pkg::SHALLOW_FILTER_CYC);
    end

    // capacitor in use by recovery or watchdog
    cap_active = (st_q.uv == ssw_pkg::SSW_UV_RECOV) || (st_q.wd != ssw_pkg::SSW_WD_OFF);
    // one oscillator period ends at the bottom of the discharge ramp
    period_end = cap_active & st_q.ramp_done & ~st_q.charging & osc_tick;
    wd_kick_taken = kick_rise & (st_q.wd == ssw_pkg::SSW_WD_RUN);

    // undervoltage path
    case (st_q.uv)
      ssw_pkg::SSW_UV_OK: begin
        st_d.uv_cnt = '0;
        if (vcc_below_2v0) begin
          st_d.uv = ssw_pkg::SSW_UV_LOW;
        end else if (vcc_below_threshold) begin
          st_d.uv = ssw_pkg::SSW_UV_FILT;
        end
      end
      ssw_pkg::SSW_UV_FILT: begin
        if (vcc_below_2v0) begin
          st_d.uv = ssw_pkg::SSW_UV_LOW;
        end else if (!vcc_below_threshold) begin
          st_d.uv     = ssw_pkg::SSW_UV_OK;
          st_d.uv_cnt = '0;
        end else if (st_q.uv_cnt >= uv_target - 1'b1) begin
          st_d.uv = ssw_pkg::SSW_UV_LOW;
        end else begin
          st_d.uv_cnt = st_q.uv_cnt + 1'b1;
        end
      end
      ssw_pkg::SSW_UV_LOW: begin
        st_d.rec_cnt = '0;
        if (!vcc_below_threshold && !vcc_below_2v0) begin
          st_d.uv = ssw_pkg::SSW_UV_RECOV;
        end
      end
      ssw_pkg::SSW_UV_RECOV: begin
        if (vcc_below_threshold || vcc_below_2v0) begin
          st_d.uv = ssw_pkg::SSW_UV_LOW;
        end else if (period_end) begin
          if (st_q.rec_cnt == ssw_pkg::REC_CNT_W'(ssw_pkg::RECOVERY_PERIODS - 1)) begin
            st_d.uv     = ssw_pkg::SSW_UV_OK;
            st_d.uv_cnt = '0;
          end else begin
            st_d.rec_cnt = st_q.rec_cnt + 1'b1;
          end
        end
      end
      default: begin
        st_d.uv = ssw_pkg::SSW_UV_OK;
      end
    endcase

    // watchdog path
    case (st_q.wd)
      ssw_pkg::SSW_WD_OFF: begin
        st_d.wd_cnt   = '0;
        st_d.hold_cnt = '0;
        if (wd_enabled) begin
          st_d.wd = ssw_pkg::SSW_WD_RUN;
        end
      end
      ssw_pkg::SSW_WD_RUN: begin
        if (!wd_enabled) begin
          st_d.wd = ssw_pkg::SSW_WD_OFF;
        end else if (wd_kick_taken) begin
          st_d.wd_cnt = '0;
        end else if (period_end) begin
          if (st_q.wd_cnt == ssw_pkg::WD_CNT_W'(ssw_pkg::WD_WINDOW_PERIODS - 1)) begin
            st_d.wd       = ssw_pkg::SSW_WD_HOLD;
            st_d.hold_cnt = '0;
          end else begin
            st_d.wd_cnt = st_q.wd_cnt + 1'b1;
          end
        end
      end
      ssw_pkg::SSW_WD_HOLD: begin
        // enable is not looked at until the hold has run out
        if (period_end) begin
          if (st_q.hold_cnt == ssw_pkg::HOLD_CNT_W'(ssw_pkg::WD_HOLD_PERIODS - 1)) begin
            st_d.wd     = wd_enabled ? ssw_pkg::SSW_WD_RUN : ssw_pkg::SSW_WD_OFF;
            st_d.wd_cnt = '0;
          end else begin
            st_d.hold_cnt = st_q.hold_cnt + 1'b1;
          end
        end
      end
      default: begin
        st_d.wd = ssw_pkg::SSW_WD_OFF;
      end
    endcase

    // oscillator phase tracking
    if (!cap_active) begin
      st_d.charging  = 1'b1;
      st_d.ramp_done = 1'b0;
    end else if (wd_kick_taken) begin
      if (st_q.charging) begin
        st_d.charging  = 1'b0;
        st_d.ramp_done = 1'b1;
      end
    end else if (osc_tick) begin
      if (!st_q.ramp_done) begin
        st_d.ramp_done = 1'b1;
        st_d.charging  = 1'b0;
      end else begin
        st_d.charging = ~st_q.charging;
      end
    end

    // capacitor drive pins, clamp when idle
    st_d.cap_clamp  = ~((st_d.uv == ssw_pkg::SSW_UV_RECOV) ||
                        (st_d.wd != ssw_pkg::SSW_WD_OFF));
    st_d.cap_charge = ~st_d.cap_clamp & st_d.charging;

    // combined fault output
    fault_now = (st_d.uv == ssw_pkg::SSW_UV_LOW) || (st_d.uv == ssw_pkg::SSW_UV_RECOV) ||
                (st_d.wd == ssw_pkg::SSW_WD_HOLD);
    st_d.fault_n = ~fault_now;

    // fault-to-reset filter
    if (st_q.fault_n) begin
      st_d.rf_cnt = '0;
    end else if (st_q.rf_cnt != st_q.rf_limit) begin
      st_d.rf_cnt = st_q.rf_cnt + 1'b1;
    end
    if (st_q.aux_mon) begin
      st_d.reset_n = ~aux_undervoltage;
    end else begin
      st_d.reset_n = st_q.fault_n | (st_q.rf_cnt != st_q.rf_limit);
    end

    st_d.aux_on = pins[ssw_pkg::PIN_AUX_EN];

    // status word
    status_word = '0;
    status_word[ssw_pkg::ST_FAULT_N_BIT]          = st_q.fault_n;
    status_word[ssw_pkg::ST_RESET_N_BIT]          = st_q.reset_n;
    status_word[ssw_pkg::ST_UV_LSB +: 2]          = st_q.uv;
    status_word[ssw_pkg::ST_WD_LSB +: 2]          = st_q.wd;
    status_word[ssw_pkg::ST_CHARGING_BIT]         = st_q.charging;
    status_word[ssw_pkg::ST_RAMP_BIT]             = st_q.ramp_done;
    status_word[ssw_pkg::ST_WDCNT_LSB +: ssw_pkg::WD_CNT_W] = st_q.wd_cnt;

    // avalon slave: one wait cycle, then the access completes
    merged = 32'h0000_0000;
    if ((avs_read || avs_write) && st_q.waitreq) begin
      st_d.waitreq = 1'b0;
      st_d.rdata   = 32'h0000_0000;
      if (avs_read) begin
        case (reg_word(avs_address))
          reg_word(ssw_pkg::CTRL_OFS):    st_d.rdata[ssw_pkg::CTRL_AUXMON_BIT] = st_q.aux_mon;
          reg_word(ssw_pkg::RSTFILT_OFS): st_d.rdata[ssw_pkg::RF_CNT_W-1:0]    = st_q.rf_limit;
          reg_word(ssw_pkg::STATUS_OFS):  st_d.rdata = status_word;
          default:                        st_d.rdata = 32'h0000_0000;
        endcase
      end
    end else if (!st_q.waitreq) begin
      st_d.waitreq = 1'b1;
      if (avs_write) begin
        case (reg_word(avs_address))
          reg_word(ssw_pkg::CTRL_OFS): begin
            merged = lane_merge({31'h0, st_q.aux_mon}, avs_writedata, avs_byteenable);
            st_d.aux_mon = merged[ssw_pkg::CTRL_AUXMON_BIT];
          end
          reg_word(ssw_pkg::RSTFILT_OFS): begin
            merged = lane_merge({16'h0000, st_q.rf_limit}, avs_writedata, avs_byteenable);
            st_d.rf_limit = merged[ssw_pkg::RF_CNT_W-1:0];
          end
          default: begin
            merged = 32'h0000_0000;
          end
        endcase
      end
    end
  end

  // ==========================================================================
  // state register
  // ==========================================================================
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q            <= '0;
      st_q.uv         <= ssw_pkg::SSW_UV_LOW;
      st_q.wd         <= ssw_pkg::SSW_WD_OFF;
      st_q.charging   <= 1'b1;
      st_q.rf_limit   <= ssw_pkg::RSTFILT_RESET;
      st_q.fault_n    <= 1'b0;
      st_q.reset_n    <= 1'b0;
      st_q.cap_clamp  <= 1'b1;
      st_q.waitreq    <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================================
  // outputs
  // ==========================================================================
  assign fault_n                = st_q.fault_n;
  assign reset_n                = st_q.reset_n;
  assign aux_output_on          = st_q.aux_on;
  assign delay_capacitor_charge = st_q.cap_charge;
  assign delay_capacitor_clamp  = st_q.cap_clamp;
  assign avs_readdata           = st_q.rdata;
  assign avs_waitrequest        = st_q.waitreq;

endmodule

// ---- tb/ssw_mcu_model.sv ----
// microcontroller kick source and delay capacitor oscillator model
`timescale 1ns/1ns
module ssw_mcu_model #(
  parameter int HALF      = 4,
  parameter int KICK_HALF = 40
) (
  // clock and bench control
  input  wire logic clk,
  input  wire logic kick_on,
  // capacitor drive from the device
  input  wire logic charge,
  input  wire logic clamp,
  // pins back to the device
  output logic      watchdog_kick,
  output logic      osc_tick
);
  int   kc = 0;
  int   oc = 0;
  logic dir = 1'b0;
  initial watchdog_kick = 1'b0;
  initial osc_tick = 1'b0;
  // square wave while kicking, level held when told to starve the device
  always @(posedge clk) begin
    kc <= (kc == KICK_HALF - 1) ? 0 : kc + 1;
    if (kick_on && kc == KICK_HALF - 1) watchdog_kick <= !watchdog_kick;
  end
  // ramp restarts on clamp or reversal; one-cycle tick at each ramp end
  always @(posedge clk) begin
    dir <= charge;
    osc_tick <= !clamp && dir == charge && oc == HALF - 1;
    oc <= (clamp || dir != charge || oc == HALF - 1) ? 0 : oc + 1;
  end
endmodule

// ---- tb/ssw_supervisor_monitor.sv ----
// concurrent checks on the supervisor pins
`timescale 1ns/1ns
module ssw_supervisor_monitor (
  // clock, reset and inputs
  input wire logic clk,
  input wire logic rst,
  input wire logic vcc_below_threshold,
  input wire logic vcc_below_2v0,
  input wire logic aux_undervoltage,
  input wire logic osc_tick,
  input wire logic watchdog_kick,
  input wire logic watchdog_enable_pin,
  input wire logic aux_enable,
  // device outputs
  input wire logic fault_n,
  input wire logic reset_n,
  input wire logic aux_output_on,
  input wire logic delay_capacitor_charge,
  input wire logic delay_capacitor_clamp
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  logic [8:0] uv_q;
  logic [8:0] rec_q;
  logic [8:0] low_q;
  wire logic  dis = osc_tick && !delay_capacitor_charge && !delay_capacitor_clamp;
  // below cycles, period ends since a dip, period ends while fault low
  always_ff @(posedge clk) begin
    uv_q <= (rst || !vcc_below_threshold) ? 9'h000 : uv_q + {8'h00, uv_q != 9'h1ff};
    rec_q <= (rst || vcc_below_threshold) ? 9'h000 : rec_q + {8'h00, dis && rec_q != 9'h1ff};
    low_q <= (rst || fault_n) ? 9'h000 : low_q + {8'h00, dis && low_q != 9'h1ff};
  end
  chk_fast_drop: assert property (vcc_below_2v0 |-> ##[1:3] !fault_n)
    else $error("fault output late after deep supply loss");
  chk_uv_filter: assert property (uv_q == 9'h19a |-> !fault_n)
    else $error("fault output high after long dip");
  chk_recovery_len: assert property ($rose(fault_n) |-> rec_q >= 9'h07f)
    else $error("fault output released before recovery periods");
  chk_hold_len: assert property ($rose(fault_n) |-> low_q >= 9'h010)
    else $error("fault output released before hold periods");
  chk_reset_rise: assert property ($rose(fault_n) && !aux_undervoltage |=> reset_n)
    else $error("secondary reset not released");
  chk_reset_fall: assert property ($fell(reset_n) |-> aux_undervoltage || !$past(fault_n, 40))
    else $error("secondary reset fell too early");
  chk_clamp_idle: assert property ((!watchdog_enable_pin && fault_n)[*8] |-> delay_capacitor_clamp)
    else $error("capacitor not clamped while idle");
  chk_kick_resync: assert property ($rose(watchdog_kick) && delay_capacitor_charge && fault_n
      && watchdog_enable_pin |-> ##[1:7] !delay_capacitor_charge)
    else $error("kick did not turn ramp to discharge");
  chk_aux_follow: assert property ($stable(aux_enable)[*6] |-> aux_output_on == aux_enable)
    else $error("aux output does not follow enable");
  cov_wd_trip: cover property (fault_n && watchdog_enable_pin ##1 !fault_n);
  cov_recovery: cover property ($rose(fault_n));
  cov_aux_mode: cover property (aux_undervoltage && !reset_n);
endmodule
bind ssw_supervisor ssw_supervisor_monitor u_mon (
  .clk(clk), .rst(rst), .vcc_below_threshold(vcc_below_threshold),
  .vcc_below_2v0(vcc_below_2v0), .aux_undervoltage(aux_undervoltage), .osc_tick(osc_tick),
  .watchdog_kick(watchdog_kick), .watchdog_enable_pin(watchdog_enable_pin),
  .aux_enable(aux_enable), .fault_n(fault_n), .reset_n(reset_n), .aux_output_on(aux_output_on),
  .delay_capacitor_charge(delay_capacitor_charge), .delay_capacitor_clamp(delay_capacitor_clamp)
);

// ---- tb/ssw_supervisor_tb.sv ----
// self-checking bench for the supply supervisor
`timescale 1ns/1ns
module ssw_supervisor_tb;
  // ==========
  // stimulus, pins and counters
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        vlow = 1'b0;
  logic        v25 = 1'b0;
  logic        v20 = 1'b0;
  logic        auxuv = 1'b0;
  logic        wden = 1'b0;
  logic        adj = 1'b0;
  logic        auxen = 1'b0;
  logic        kick_on = 1'b0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [3:0]  adr = 4'h0;
  logic [31:0] wd = 32'h0000_0000;
  logic [31:0] rdat;
  logic [31:0] r;
  logic        waitreq, fault_n, reset_n, aux_on, chg, clmp, kick, tick;
  wire logic [3:0] obs = {aux_on, clmp, reset_n, fault_n};
  int          n_tests = 0;
  int          err_total = 0;
  int          dtk = 0;
  int          n, t0;
  int          lim[3] = '{ssw_pkg::EXT_FILTER_CYC, ssw_pkg::SHALLOW_FILTER_CYC,
                          ssw_pkg::DEEP_FILTER_CYC};
  initial begin
    forever #5 clk = ~clk;
  end
  // discharge period ends seen at the pins
  always @(posedge clk) if (tick && !chg && !clmp) dtk <= dtk + 1;
  ssw_supervisor DUT (
    .clk(clk), .rst(rst), .vcc_below_threshold(vlow), .vcc_below_2v5(v25),
    .vcc_below_2v0(v20), .aux_undervoltage(auxuv), .osc_tick(tick), .watchdog_kick(kick),
    .watchdog_enable_pin(wden), .threshold_adjust(adj), .aux_enable(auxen),
    .fault_n(fault_n), .reset_n(reset_n), .aux_output_on(aux_on),
    .delay_capacitor_charge(chg), .delay_capacitor_clamp(clmp), .avs_address(adr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_byteenable(4'hf),
    .avs_readdata(rdat), .avs_waitrequest(waitreq)
  );
  ssw_mcu_model mcu (
    .clk(clk), .kick_on(kick_on), .charge(chg), .clamp(clmp),
    .watchdog_kick(kick), .osc_tick(tick)
  );
  // ==========
  // tasks
  task automatic chk(input string nm, input logic [31:0] lo, hi, got);
    n_tests++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      err_total++;
      $display("Error %s expected %0d..%0d seen %0d", nm, lo, hi, got);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    adr <= a;
    wd <= d;
    rd <= !w;
    wr <= w;
    // request stands until the edge that samples waitrequest low
    @(posedge clk);
    while (waitreq !== 1'b0 && k < 20) begin
      @(posedge clk);
      k++;
    end
    r = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    if (k >= 20) begin
      err_total++;
      $display("Error bus waitrequest expected 0 seen %b", waitreq);
    end
    @(posedge clk);
  endtask
  task automatic wait_for(input int sel, input logic lvl, input int lim_c);
    n = 0;
    @(negedge clk);
    while (obs[sel] !== lvl && n < lim_c) begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ==========
  // tests
  initial begin
    repeat (16) @(posedge clk);
    @(negedge clk);
    chk("clamp in reset", 1, 1, clmp);
    @(posedge clk);
    rst <= 1'b0;
    t0 = dtk;
    bus(1'b0, 4'h4, 0);
    chk("filter reg reset", 32'h0000_0064, 32'h0000_0064, r);
    bus(1'b0, 4'hc, 0);
    chk("unmapped read", 0, 0, r);
    bus(1'b1, 4'h4, 32'h0000_0032);
    wait_for(0, 1'b1, 3000);
    chk("first recovery", 127, 128, dtk - t0);
    $display("test reset done");
    for (int i = 0; i < 3; i++) begin
      adj <= (i == 0);
      repeat (6) @(posedge clk);
      vlow <= 1'b1;
      repeat (lim[i] - 10) @(posedge clk);
      vlow <= 1'b0;
      wait_for(0, 1'b0, 30);
      chk("short dip", 30, 30, n);
      vlow <= 1'b1;
      v25 <= (i == 2);
      wait_for(0, 1'b0, 600);
      chk("filter time", lim[i], lim[i] + 3, n);
      wait_for(1, 1'b0, 200);
      chk("fault to reset", 49, 53, n);
      vlow <= 1'b0;
      v25 <= 1'b0;
      wait_for(0, 1'b1, 3000);
    end
    v20 <= 1'b1;
    vlow <= 1'b1;
    wait_for(0, 1'b0, 20);
    chk("fast drop", 0, 3, n);
    v20 <= 1'b0;
    vlow <= 1'b0;
    wait_for(0, 1'b1, 3000);
    $display("test undervoltage done");
    wden <= 1'b1;
    kick_on <= 1'b1;
    wait_for(0, 1'b0, 1500);
    chk("kicked quiet", 1500, 1500, n);
    do @(negedge clk); while (kick !== 1'b0);
    do @(negedge clk); while (kick !== 1'b1);
    @(posedge clk);
    kick_on <= 1'b0;
    t0 = dtk;
    wait_for(0, 1'b0, 2000);
    chk("window periods", 47, 49, dtk - t0);
    kick_on <= 1'b1;
    wden <= 1'b0;
    t0 = dtk;
    wait_for(0, 1'b1, 2000);
    chk("hold periods", 16, 17, dtk - t0);
    wait_for(2, 1'b1, 10);
    chk("clamp after hold", 0, 2, n);
    wait_for(0, 1'b0, 800);
    chk("disabled quiet", 800, 800, n);
    $display("test watchdog done");
    for (int i = 1; i >= 0; i--) begin
      auxen <= i[0];
      wait_for(3, i[0], 20);
      chk("aux output", 3, 7, n);
    end
    bus(1'b1, 4'h0, 32'h0000_0001);
    auxuv <= 1'b1;
    wait_for(1, 1'b0, 20);
    chk("aux monitor low", 0, 3, n);
    auxuv <= 1'b0;
    wait_for(1, 1'b1, 20);
    chk("aux monitor high", 0, 3, n);
    bus(1'b0, 4'h8, 0);
    chk("status fault bit", 1, 1, r[0]);
    $display("test aux done");
    print_verdict();
  end
  // hang guard
  initial begin
    #1_000_000;
    err_total++;
    $display("Error timeout expected finish seen none");
    print_verdict();
  end
endmodule
